/* src/emq_map.svh */
// Behaviour
// R1: Queue holds ten messages, first in first out
// R2: Each read pops and returns oldest message
// R3: Filling queue puts code 350 in last slot
// R4: Queue is empty after reset
// R5: Read of empty queue returns code 0
// R6: Codes are signed; negative standard, positive maker
// R7: Clear command empties the queue
// R8: Reset filter admits error codes, blocks status codes
// R9: Enable list blocks all, then admits listed codes
// R10: Enable query reports every admitted code; the code reports only admitted codes inside the filter window
// R11: Lists take single codes, commas and ranges
// R12: Empty enable list leaves every code blocked; negative codes outside the filter window still pass by the sign rule
// R13: Disable list blocks codes; blocked codes not stored
// R14: Disable query reports every blocked code; the code reports only blocked codes inside the filter window
// R15: Two read queries perform the same pop
// R16: With overflow stored, further messages are dropped
`ifndef EMQ_MAP_SVH
`define EMQ_MAP_SVH
`define EMQ_CODE_W     16
`define EMQ_Q_DEPTH    10
`define EMQ_FIFO_DEPTH 8
`define EMQ_CODE_NOERR 16'h0000
`define EMQ_CODE_OVF   16'h015E
`define EMQ_CODE_MIN   (-512)
`define EMQ_CODE_SPAN  1024
`endif

/* src/emq_pkg.sv */
`include "emq_map.svh"
`default_nettype none
package emq_pkg;
    typedef logic signed [`EMQ_CODE_W-1:0] emq_code_t;
    typedef enum logic [2:0] {
        EMQ_OP_READ,
        EMQ_OP_READ_ALT,
        EMQ_OP_CLEAR,
        EMQ_OP_EN_START,
        EMQ_OP_EN_ADD,
        EMQ_OP_DIS_ADD,
        EMQ_OP_EN_QUERY,
        EMQ_OP_DIS_QUERY
    } emq_op_e;
    typedef struct packed {
        emq_op_e   op;
        emq_code_t lo;
        emq_code_t hi;
    } emq_cmd_s;
    typedef struct packed {
        emq_code_t code;
        logic      last;
    } emq_rsp_s;
endpackage
`default_nettype wire

/* src/emq_queue.sv */
`include "emq_map.svh"
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module emq_fifo #(
    parameter int W     = `EMQ_CODE_W,
    parameter int DEPTH = `EMQ_FIFO_DEPTH
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0]  mem_r [DEPTH];
    logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0]   cnt_r, cnt_nxt;
    logic          wr_en, rd_en;

    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rd_r];
    assign wr_en     = in_valid && in_ready;
    assign rd_en     = out_valid && out_ready;

    always_comb begin
        wr_nxt  = wr_r;
        rd_nxt  = rd_r;
        cnt_nxt = cnt_r;
        if (wr_en) begin
            wr_nxt = (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
        end
        if (rd_en) begin
            rd_nxt = (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
        end
        if (wr_en && !rd_en) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (rd_en && !wr_en) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            wr_r  <= wr_nxt;
            rd_r  <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage carries no reset so it maps onto plain memory
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_r[wr_r] <= in_data;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module emq_queue #(
    parameter int DEPTH    = `EMQ_Q_DEPTH,
    parameter int FIFO_D   = `EMQ_FIFO_DEPTH,
    parameter int CODE_MIN = `EMQ_CODE_MIN,
    parameter int SPAN     = `EMQ_CODE_SPAN
) (
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic               ev_valid,
    output logic                    ev_ready,
    input  wire emq_pkg::emq_code_t ev_code,
    input  wire logic               cmd_valid,
    output logic                    cmd_ready,
    input  wire emq_pkg::emq_cmd_s  cmd,
    output logic                    rsp_valid,
    output emq_pkg::emq_rsp_s       rsp,
    output logic [$clog2(DEPTH):0]  q_count
);
    localparam int CW = `EMQ_CODE_W;
    localparam int AW = $clog2(DEPTH);
    localparam int SW = $clog2(SPAN);

    // Error-class codes (negative) pass after reset, status-class ones do not
    function automatic logic [SPAN-1:0] flt_rst_f();
        logic [SPAN-1:0] v;
        v = '0;
        for (int i = 0; i < SPAN; i++) begin
            v[i] = (i + CODE_MIN) < 0;
        end
        return v;
    endfunction
    localparam logic [SPAN-1:0] FLT_RST = flt_rst_f();  // [R8]

    typedef enum logic [1:0] {EMQ_ST_IDLE, EMQ_ST_SCAN, EMQ_ST_END} emq_st_e;

    emq_st_e            st_r, st_nxt;
    emq_pkg::emq_code_t mem_r [DEPTH];
    logic [AW-1:0]      rd_r, rd_nxt, wr_idx, tail_idx;
    logic [AW:0]        cnt_r, cnt_nxt;
    logic [SPAN-1:0]    flt_r, flt_nxt, rng_mask;
    logic [SW-1:0]      scan_r, scan_nxt;
    logic               want_r, want_nxt;
    logic               rv_r, rv_nxt;
    emq_pkg::emq_rsp_s  rsp_r, rsp_nxt;
    logic               wr_en;
    emq_pkg::emq_code_t wr_code;
    logic               f_valid, f_ready, admit, in_win;
    emq_pkg::emq_code_t f_code, rlo, rhi;
    logic [CW-1:0]      f_off;
    logic               cmd_take;

    ////////////////////////////////////////////////////////////////////////////
    // Event sources stall here while commands or scans hold the queue
    emq_fifo #(.W(CW), .DEPTH(FIFO_D)) u_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (ev_valid),
        .in_ready  (ev_ready),
        .in_data   (ev_code),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_code)
    );

    assign cmd_ready = (st_r == EMQ_ST_IDLE);
    assign cmd_take  = cmd_valid && cmd_ready;
    assign f_ready   = (st_r == EMQ_ST_IDLE) && !cmd_valid;

    // Codes outside the filter window fall back to the sign rule
    assign f_off  = CW'(f_code - CW'(CODE_MIN));  // [R6]
    assign in_win = (f_code >= CW'(CODE_MIN)) && (f_code < CW'(CODE_MIN + SPAN));
    assign admit  = in_win ? flt_r[f_off[SW-1:0]] : (f_code < 0);

    // Either order of range bounds is accepted
    assign rlo = (cmd.lo <= cmd.hi) ? cmd.lo : cmd.hi;  // [R11]
    assign rhi = (cmd.lo <= cmd.hi) ? cmd.hi : cmd.lo;

    for (genvar g = 0; g < SPAN; g++) begin : g_rng
        assign rng_mask[g] = (CW'(g + CODE_MIN) >= rlo) && (CW'(g + CODE_MIN) <= rhi);  // [R11]
    end

    assign wr_idx   = AW'((32'(rd_r) + 32'(cnt_r)) % DEPTH);
    assign tail_idx = AW'((32'(rd_r) + DEPTH - 1) % DEPTH);

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt   = st_r;
        rd_nxt   = rd_r;
        cnt_nxt  = cnt_r;
        flt_nxt  = flt_r;
        scan_nxt = scan_r;
        want_nxt = want_r;
        rv_nxt   = 1'b0;
        rsp_nxt  = rsp_r;
        wr_en    = 1'b0;
        wr_code  = f_code;
        case (st_r)
            EMQ_ST_IDLE: begin
                if (cmd_take) begin
                    case (cmd.op)
                        emq_pkg::EMQ_OP_READ, emq_pkg::EMQ_OP_READ_ALT: begin  // [R15]
                            rv_nxt       = 1'b1;
                            rsp_nxt.last = 1'b1;
                            if (cnt_r == '0) begin
                                rsp_nxt.code = `EMQ_CODE_NOERR;  // [R5]
                            end else begin
                                rsp_nxt.code = mem_r[rd_r];  // [R2]
                                rd_nxt  = (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
                                cnt_nxt = cnt_r - 1'b1;
                            end
                        end
                        emq_pkg::EMQ_OP_CLEAR: begin
                            cnt_nxt = '0;  // [R7]
                            rd_nxt  = '0;
                        end
                        emq_pkg::EMQ_OP_EN_START: flt_nxt = '0;  // [R9] [R12]
                        emq_pkg::EMQ_OP_EN_ADD:   flt_nxt = flt_r | rng_mask;  // [R9]
                        emq_pkg::EMQ_OP_DIS_ADD:  flt_nxt = flt_r & ~rng_mask;  // [R13]
                        default: begin
                            st_nxt   = EMQ_ST_SCAN;  // [R10] [R14]
                            scan_nxt = '0;
                            want_nxt = (cmd.op == emq_pkg::EMQ_OP_EN_QUERY);
                        end
                    endcase
                end else if (f_valid && admit) begin  // [R13]
                    if (cnt_r < (AW+1)'(DEPTH-1)) begin
                        wr_en   = 1'b1;  // [R1]
                        cnt_nxt = cnt_r + 1'b1;
                    end else if (cnt_r == (AW+1)'(DEPTH-1)) begin
                        wr_en   = 1'b1;
                        wr_code = `EMQ_CODE_OVF;  // [R3]
                        cnt_nxt = cnt_r + 1'b1;
                    end
                    // A full queue drops the message  [R16]
                end
            end
            EMQ_ST_SCAN: begin
                if (flt_r[scan_r] == want_r) begin
                    rv_nxt  = 1'b1;
                    rsp_nxt = '{code: CW'(32'(scan_r) + CODE_MIN), last: 1'b0};
                end
                if (scan_r == SW'(SPAN-1)) begin
                    st_nxt = EMQ_ST_END;
                end else begin
                    scan_nxt = scan_r + 1'b1;
                end
            end
            default: begin
                rv_nxt  = 1'b1;
                rsp_nxt = '{code: `EMQ_CODE_NOERR, last: 1'b1};
                st_nxt  = EMQ_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r   <= EMQ_ST_IDLE;
            rd_r   <= '0;
            cnt_r  <= '0;  // [R4]
            flt_r  <= FLT_RST;  // [R8]
            scan_r <= '0;
            want_r <= 1'b0;
            rv_r   <= 1'b0;
            rsp_r  <= '0;
        end else begin
            st_r   <= st_nxt;
            rd_r   <= rd_nxt;
            cnt_r  <= cnt_nxt;
            flt_r  <= flt_nxt;
            scan_r <= scan_nxt;
            want_r <= want_nxt;
            rv_r   <= rv_nxt;
            rsp_r  <= rsp_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_r[wr_idx] <= wr_code;
        end
    end

    assign rsp_valid = rv_r;
    assign rsp       = rsp_r;
    assign q_count   = cnt_r;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic is_read, push_try;
    assign is_read  = cmd_take && (cmd.op == emq_pkg::EMQ_OP_READ ||
                                   cmd.op == emq_pkg::EMQ_OP_READ_ALT);
    assign push_try = (st_r == EMQ_ST_IDLE) && !cmd_valid && f_valid;

    sequence s_fill_last;
        push_try && admit && cnt_r == (AW+1)'(DEPTH-1);
    endsequence
    sequence s_full_kept;
        cnt_r == (AW+1)'(DEPTH) && mem_r[tail_idx] == `EMQ_CODE_OVF;
    endsequence

    a_empty_read_zero: assert property (is_read && cnt_r == '0 |=>  // [R5]
        rsp_valid && rsp.last && rsp.code == `EMQ_CODE_NOERR)
        else $error("empty read did not answer code 0");
    a_read_pops_oldest: assert property (is_read && cnt_r != '0 |=>  // [R2]
        rsp_valid && rsp.code == $past(mem_r[rd_r]) && cnt_r == $past(cnt_r) - 1'b1)
        else $error("read did not pop the oldest entry");
    a_depth_bound: assert property (cnt_r <= (AW+1)'(DEPTH))  // [R1]
        else $error("queue count above depth");
    a_overflow_slot: assert property (s_fill_last |=> s_full_kept)  // [R3]
        else $error("overflow code missing from last slot");
    a_full_drops: assert property ((s_full_kept and push_try) |=>  // [R16]
        (s_full_kept and $stable(rd_r)))
        else $error("full queue accepted a message");
    a_clear_empties: assert property (cmd_take && cmd.op == emq_pkg::EMQ_OP_CLEAR |=>  // [R7]
        cnt_r == '0)
        else $error("clear left entries behind");
    a_blocked_dropped: assert property (push_try && !admit |=> $stable(cnt_r))  // [R13]
        else $error("blocked code was stored");
    a_enable_reset: assert property (cmd_take && cmd.op == emq_pkg::EMQ_OP_EN_START |=>  // [R9]
        flt_r == '0)
        else $error("enable list did not block all codes");
    a_enable_admits: assert property (cmd_take && cmd.op == emq_pkg::EMQ_OP_EN_ADD |=>  // [R11]
        (flt_r & $past(rng_mask)) == $past(rng_mask))
        else $error("enable list left a listed code blocked");
    a_disable_blocks: assert property (cmd_take && cmd.op == emq_pkg::EMQ_OP_DIS_ADD |=>  // [R13]
        (flt_r & $past(rng_mask)) == '0)
        else $error("disable list left a listed code admitted");
    a_scan_steps: assert property (st_r == EMQ_ST_SCAN && scan_r != SW'(SPAN-1) |=>  // [R10]
        st_r == EMQ_ST_SCAN && scan_r == $past(scan_r) + 1'b1)
        else $error("query scan stalled");
    a_scan_reports: assert property (st_r == EMQ_ST_SCAN && flt_r[scan_r] == want_r |=>  // [R14]
        rsp_valid && !rsp.last)
        else $error("query skipped a matching code");
endmodule
`default_nettype wire

/* verif/emq_host.sv */
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module emq_host (
    input  wire logic          clk,
    input  wire logic          cmd_ready,
    output logic               cmd_valid,
    output emq_pkg::emq_cmd_s  cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
    end
    // Request held until the edge that samples cmd_ready high
    task automatic send(input emq_pkg::emq_op_e op, input int lo, input int hi);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= '{op, 16'(lo), 16'(hi)};
        do @(posedge clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* verif/tb_emq_queue.sv */
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module tb_emq_queue;
    timeunit 1ns;
    timeprecision 1ps;
    // Small filter window keeps each query scan short
    localparam int CMIN = -32;
    localparam int SPAN = 64;
    logic               clk = 1'b0;
    logic               rst_b = 1'b0;
    logic               ev_valid = 1'b0;
    logic               ev_ready;
    emq_pkg::emq_code_t ev_code = '0;
    logic               cmd_valid;
    logic               cmd_ready;
    logic               rsp_valid;
    emq_pkg::emq_cmd_s  cmd;
    emq_pkg::emq_rsp_s  rsp;
    logic [4:0]         q_count;
    emq_pkg::emq_rsp_s  exp_q[$];
    emq_pkg::emq_code_t mq[$];
    int                 fails = 0;
    int                 total_checks = 0;
    int                 c;

    emq_queue #(.CODE_MIN(CMIN), .SPAN(SPAN)) i_emq_queue (
        .clk(clk), .rst_b(rst_b), .ev_valid(ev_valid), .ev_ready(ev_ready),
        .ev_code(ev_code), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
        .rsp_valid(rsp_valid), .rsp(rsp), .q_count(q_count));
    emq_host i_emq_host (.clk(clk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd(cmd));

    always #10 clk = ~clk;

    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xp(input int code, input logic last);
        exp_q.push_back('{16'(code), last});
    endtask
    task automatic push_ev(input int code);
        @(posedge clk);
        ev_valid <= 1'b1;
        ev_code <= 16'(code);
        do @(posedge clk); while (ev_ready !== 1'b1);
        ev_valid <= 1'b0;
    endtask
    // Reference queue: nine ordinary entries, then the overflow marker
    task automatic store(input int code);
        if (mq.size() < 9) mq.push_back(16'(code));
        else if (mq.size() == 9) mq.push_back(16'h015E);
    endtask
    task automatic rd(input emq_pkg::emq_op_e op);
        xp(mq.size() ? int'(mq.pop_front()) : 0, 1'b1);
        i_emq_host.send(op, 0, 0);
    endtask
    task automatic wait_cnt(input int n);
        int k;
        for (k = 0; k < 200 && q_count !== 5'(n); k++) @(posedge clk);
        check(17'(q_count), 17'(n));
    endtask
    task automatic drain(input string name);
        int k;
        for (k = 0; k < 2000 && exp_q.size() != 0; k++) @(posedge clk);
        repeat (3) @(posedge clk);
        check(17'(exp_q.size()), 17'h0_0000);
        $display("test %s done", name);
    endtask
    task automatic summarize;
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) check(rsp, ~rsp);
            else check(rsp, exp_q.pop_front());
        end
    end

    initial begin
        #(20_000 * 20);
        fails++;
        summarize();
    end

    initial begin
        void'($urandom(19967));
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check(17'(q_count), 17'h0_0000);
        check(17'(ev_ready), 17'h0_0001);
        check(17'(cmd_ready), 17'h0_0001);
        rd(emq_pkg::EMQ_OP_READ);
        drain("empty");
        push_ev(-5);
        push_ev(5);
        push_ev(-600);
        push_ev(600);
        store(-5);
        store(-600);
        wait_cnt(2);
        rd(emq_pkg::EMQ_OP_READ);
        rd(emq_pkg::EMQ_OP_READ_ALT);
        drain("default_filter");
        for (int i = 0; i < 12; i++) begin
            c = -int'($urandom_range(512, 1));
            push_ev(c);
            store(c);
        end
        wait_cnt(10);
        for (int i = 0; i < 11; i++) rd(i % 2 ? emq_pkg::EMQ_OP_READ_ALT : emq_pkg::EMQ_OP_READ);
        drain("overflow");
        push_ev(-1);
        push_ev(-2);
        wait_cnt(2);
        i_emq_host.send(emq_pkg::EMQ_OP_CLEAR, 0, 0);
        mq.delete();
        wait_cnt(0);
        rd(emq_pkg::EMQ_OP_READ);
        drain("clear");
        i_emq_host.send(emq_pkg::EMQ_OP_EN_START, 0, 0);
        i_emq_host.send(emq_pkg::EMQ_OP_EN_ADD, -10, -12);
        i_emq_host.send(emq_pkg::EMQ_OP_EN_ADD, 7, 7);
        for (int v = -12; v <= -10; v++) xp(v, 1'b0);
        xp(7, 1'b0);
        xp(0, 1'b1);
        i_emq_host.send(emq_pkg::EMQ_OP_EN_QUERY, 0, 0);
        push_ev(-3);
        push_ev(-11);
        store(-11);
        wait_cnt(1);
        rd(emq_pkg::EMQ_OP_READ);
        drain("enable_list");
        i_emq_host.send(emq_pkg::EMQ_OP_EN_START, 0, 0);
        xp(0, 1'b1);
        i_emq_host.send(emq_pkg::EMQ_OP_EN_QUERY, 0, 0);
        for (int v = CMIN; v < CMIN + SPAN; v++) xp(v, 1'b0);
        xp(0, 1'b1);
        i_emq_host.send(emq_pkg::EMQ_OP_DIS_QUERY, 0, 0);
        // Status codes outside the window stay blocked, so these never land
        repeat (8) push_ev(600);
        @(posedge clk);
        check(17'(ev_ready), 17'h0_0000);
        check(17'(cmd_ready), 17'h0_0000);
        drain("empty_list");
        i_emq_host.send(emq_pkg::EMQ_OP_EN_ADD, CMIN, CMIN + SPAN - 1);
        i_emq_host.send(emq_pkg::EMQ_OP_DIS_ADD, -5, -5);
        xp(-5, 1'b0);
        xp(0, 1'b1);
        i_emq_host.send(emq_pkg::EMQ_OP_DIS_QUERY, 0, 0);
        push_ev(-5);
        push_ev(-6);
        store(-6);
        wait_cnt(1);
        rd(emq_pkg::EMQ_OP_READ_ALT);
        drain("disable_list");
        summarize();
    end
endmodule
`default_nettype wire
